// *** pcs_pkg.sv ***
// package: constants for the pci special cycle / parity / sideband block
package pcs_pkg;
  // ---------------------------------------------------------------
  // configuration address port fields
  // ---------------------------------------------------------------
  localparam int CA_EN_BIT = 31;
  localparam int CA_BUS_HI = 23;
  localparam int CA_BUS_LO = 16;
  localparam int CA_DEV_HI = 15;
  localparam int CA_DEV_LO = 11;
  localparam logic [4:0] DEV_SPECIAL = 5'h1f;
  localparam logic [7:0] BUS_LOCAL = 8'h00;
  localparam logic [1:0] TYPE1_LOW = 2'h1;
  // ---------------------------------------------------------------
  // pci commands (active-high view of c/be lines)
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // ---------------------------------------------------------------
  // special-cycle messages and power config enable bits
  // ---------------------------------------------------------------
  localparam logic [15:0] MSG_DEEP_SLEEP = 16'h0000;
  localparam logic [15:0] MSG_NAP_SLEEP = 16'h0001;
  localparam logic [15:0] MSG_UNUSED = 16'h0002;
  localparam int PM_DEEP_BIT = 0;
  localparam int PM_NAP_BIT = 1;
  localparam logic [31:0] SYSMEM_BASE = 32'h8000_0000;
  // ---------------------------------------------------------------
  // host register map (ahb-lite byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CFG_ADDR = 8'h00;
  localparam logic [7:0] REG_CFG_DATA = 8'h04;
  localparam logic [7:0] REG_PM_CFG = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FLUSH = 8'h14;
  // command register bits
  localparam int CMD_PERR_RESP_BIT = 0;
  localparam int CMD_SERR_EN_BIT = 1;
  // status register bits (error flags write one to clear)
  localparam int ST_PAR_ERR_BIT = 0;
  localparam int ST_MABORT_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_ADDR_PERR_BIT = 3;
  localparam int ST_FLUSH_ACK_BIT = 4;
  localparam int FLUSH_ACK_HOLD = 2;
  // ---------------------------------------------------------------
  // bridge master state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b011,
    ST_TURN = 3'b010,
    ST_PAR = 3'b110
  } pcs_mst_t;
endpackage : pcs_pkg

// *** pcs_if.sv ***
// interface: pci bus wires plus sidebands between bridge and agent
`timescale 1ns/1ps
interface pcs_if;
  logic [31:0] adBr; // ad driven by bridge
  logic adBrOe; // bridge ad enable
  logic [31:0] adAg; // ad driven by agent
  logic adAgOe; // agent ad enable
  logic [3:0] cbeBr; // c/be from bridge (active high view)
  logic cbeBrOe; // bridge c/be enable
  logic [3:0] cbeAg; // c/be from agent
  logic cbeAgOe; // agent c/be enable
  logic parBr; // par from bridge
  logic parBrOe; // bridge par enable
  logic parAg; // par from agent
  logic parAgOe; // agent par enable
  logic frameBr; // bridge frame, active high view
  logic frameAg; // agent frame
  logic irdyBr; // bridge irdy
  logic irdyAg; // agent irdy
  logic devselBr; // bridge devsel
  logic trdyBr; // bridge trdy
  logic perrBr; // bridge perr
  logic serrBr; // bridge serr
  logic perrAg; // agent perr
  logic serrAg; // agent serr
  logic legacyMasterClaimN; // legacy claim sideband, low active
  logic bufferFlushRequestN; // flush request, low active
  logic bufferFlushAckN; // flush acknowledge, low active
  // resolved bus values
  wire [31:0] ad = adBrOe ? adBr : (adAgOe ? adAg : 32'h0000_0000);
  wire [3:0] cbe = cbeBrOe ? cbeBr : (cbeAgOe ? cbeAg : 4'h0);
  wire par = parBrOe ? parBr : (parAgOe ? parAg : 1'b0);
  wire frame = frameBr | frameAg;
  wire irdy = irdyBr | irdyAg;
  modport bridge (
    input ad, cbe, par, frame, irdy, frameAg, irdyAg, perrAg, serrAg,
    input legacyMasterClaimN, bufferFlushRequestN,
    output adBr, adBrOe, cbeBr, cbeBrOe, parBr, parBrOe, frameBr, irdyBr,
    output devselBr, trdyBr, perrBr, serrBr, bufferFlushAckN
  );
  modport agent (
    input ad, cbe, par, frame, irdy, devselBr, trdyBr, perrBr, serrBr,
    input bufferFlushAckN,
    output adAg, adAgOe, cbeAg, cbeAgOe, parAg, parAgOe, frameAg, irdyAg,
    output perrAg, serrAg, legacyMasterClaimN, bufferFlushRequestN
  );
endinterface : pcs_if

// *** pcs_bridge.sv ***
// bridge end: ahb-lite registers, special/config cycles, parity, sidebands
`timescale 1ns/1ps
module pcs_bridge (
  input wire logic clk, // 125 mhz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic memClaim, // system memory claims current transaction
  pcs_if.bridge pci // pci side
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers for sideband pins
  // ---------------------------------------------------------------
  logic claimS1, claimS2, flushS1, flushS2;
  always_ff @(posedge clk)
  begin
    claimS1 <= pci.legacyMasterClaimN;
    claimS2 <= claimS1;
    flushS1 <= pci.bufferFlushRequestN;
    flushS2 <= flushS1;
  end
  wire claimReq = !claimS2;
  wire flushReq = !flushS2;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic [31:0] cfgAddr, pmCfg, cmdReg, pendData;
  logic [4:0] status;
  logic dWr, dAct;
  logic [7:0] dAddr;
  pcs_mst_t state;
  wire accept = hsel && hready && htrans[1];
  wire busy = state != ST_IDLE;
  wire wrCfgData = dAct && dWr && (dAddr == REG_CFG_DATA);
  wire cfgEn = cfgAddr[CA_EN_BIT];
  wire [7:0] busNum = cfgAddr[CA_BUS_HI:CA_BUS_LO];
  wire [4:0] devNum = cfgAddr[CA_DEV_HI:CA_DEV_LO];
  wire isLocal = busNum == BUS_LOCAL;
  wire isSpecial = (devNum == DEV_SPECIAL) && isLocal;
  wire [15:0] msgCode = hwdata[15:0];
  // power message gate: others reserved or unused never go out
  wire msgOk = (msgCode == MSG_DEEP_SLEEP) ? pmCfg[PM_DEEP_BIT] :
    ((msgCode == MSG_NAP_SLEEP) ? pmCfg[PM_NAP_BIT] : 1'b0);
  wire launch = wrCfgData && cfgEn && !flushReq && (!isSpecial || msgOk);
  wire [31:0] statusRd = {27'h0, status};
  // read mux decodes the address phase so hrdata stands in the data phase
  wire [7:0] rdAddr = haddr[7:0];
  wire [31:0] rdMux =
    (rdAddr == REG_CFG_ADDR) ? cfgAddr :
    (rdAddr == REG_PM_CFG) ? pmCfg :
    (rdAddr == REG_CMD) ? cmdReg :
    (rdAddr == REG_STATUS) ? statusRd :
    (rdAddr == REG_FLUSH) ? {31'h0, flushReq} : 32'h0000_0000;
  // data phase capture; unmapped reads zero, writes dropped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dAct <= 1'b0;
      dWr <= 1'b0;
      dAddr <= 8'h00;
    end
    else if (hready)
    begin
      dAct <= accept;
      dWr <= hwrite;
      dAddr <= haddr[7:0];
    end
  end
  // hold off a data-port write phase while a cycle is still on the bus
  wire stall = wrCfgData && busy;
  // busy in the coming cycle, and whether that cycle is a data-port write phase
  wire nextBusy = (state == ST_IDLE) ? (launch && !stall) : (state != ST_PAR);
  wire nextCfgWr = hready ? (accept && hwrite && (haddr[7:0] == REG_CFG_DATA)) : wrCfgData;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(nextCfgWr && nextBusy);
      hrdata <= rdMux;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers; error status flags are sticky, set wins over clear
  // ---------------------------------------------------------------
  logic parErrEv, addrErrEv, abortEv, ackOn;
  wire regWr = dAct && dWr && !stall;
  wire stClr = regWr && (dAddr == REG_STATUS);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfgAddr <= 32'h0000_0000;
      pmCfg <= 32'h0000_0000;
      cmdReg <= 32'h0000_0000;
      status <= 5'h00;
    end
    else
    begin
      if (regWr && dAddr == REG_CFG_ADDR)
        cfgAddr <= {hwdata[31], 7'h00, hwdata[23:2], 2'h0};
      if (regWr && dAddr == REG_PM_CFG)
        pmCfg <= {30'h0, hwdata[1:0]};
      if (regWr && dAddr == REG_CMD)
        cmdReg <= {30'h0, hwdata[1:0]};
      status[ST_PAR_ERR_BIT] <= parErrEv | (status[ST_PAR_ERR_BIT] &
        !(stClr && hwdata[ST_PAR_ERR_BIT]));
      status[ST_MABORT_BIT] <= abortEv | (status[ST_MABORT_BIT] &
        !(stClr && hwdata[ST_MABORT_BIT]));
      status[ST_ADDR_PERR_BIT] <= addrErrEv | (status[ST_ADDR_PERR_BIT] &
        !(stClr && hwdata[ST_ADDR_PERR_BIT]));
      status[ST_BUSY_BIT] <= busy;
      status[ST_FLUSH_ACK_BIT] <= ackOn;
    end
  end

  // ---------------------------------------------------------------
  // pci master: address, data, master-abort turnaround
  // ---------------------------------------------------------------
  logic special;
  logic [3:0] waitCnt;
  wire [31:0] type1Addr = {cfgAddr[31:2], TYPE1_LOW};
  // stable dummy address for special cycles: the address port itself
  wire [31:0] specAddr = cfgAddr;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      special <= 1'b0;
      pendData <= 32'h0000_0000;
      pci.adBr <= 32'h0000_0000;
      pci.adBrOe <= 1'b0;
      pci.cbeBr <= 4'h0;
      pci.cbeBrOe <= 1'b0;
      pci.frameBr <= 1'b0;
      pci.irdyBr <= 1'b0;
      waitCnt <= 4'h0;
      abortEv <= 1'b0;
    end
    else
    begin
      abortEv <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (launch && !stall)
          begin
            state <= ST_ADDR;
            special <= isSpecial;
            pendData <= hwdata;
            pci.adBr <= isSpecial ? specAddr : type1Addr;
            pci.cbeBr <= isSpecial ? CMD_SPECIAL : CMD_CFG_WR;
            pci.adBrOe <= 1'b1;
            pci.cbeBrOe <= 1'b1;
            pci.frameBr <= 1'b1;
          end
        end
        ST_ADDR:
        begin
          state <= ST_DATA;
          pci.adBr <= pendData; // message low, data high
          pci.cbeBr <= 4'hf;
          pci.irdyBr <= 1'b1; // valid on first irdy clock
          pci.frameBr <= 1'b0;
          waitCnt <= 4'h0;
        end
        ST_DATA:
        begin
          waitCnt <= waitCnt + 4'h1;
          // no devsel expected: end by master-abort after timeout
          if (waitCnt == 4'h4)
          begin
            state <= ST_TURN;
            pci.irdyBr <= 1'b0;
            abortEv <= !special;
          end
        end
        ST_TURN:
        begin
          state <= ST_PAR;
          pci.adBrOe <= 1'b0;
          pci.cbeBrOe <= 1'b0;
        end
        ST_PAR:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // parity: drive one clock after bridge phase, check agent phases
  // ---------------------------------------------------------------
  logic agAddrPh, agDataPh, agSpecial, phasePar;
  logic [31:0] memAddr;
  wire calcPar = ^{pci.ad, pci.cbe};
  // par trails its phase by a clock, so compare with last clock's sum
  wire parBad = phasePar != pci.par;
  wire agAddr = pci.frameAg && !agAddrPh && !pci.irdyAg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pci.parBr <= 1'b0;
      pci.parBrOe <= 1'b0;
      agAddrPh <= 1'b0;
      agDataPh <= 1'b0;
      agSpecial <= 1'b0;
      phasePar <= 1'b0;
      parErrEv <= 1'b0;
      addrErrEv <= 1'b0;
      pci.perrBr <= 1'b0;
      pci.serrBr <= 1'b0;
      memAddr <= 32'h0000_0000;
    end
    else
    begin
      pci.parBr <= ^{pci.adBr, pci.cbeBr};
      pci.parBrOe <= pci.adBrOe;
      agAddrPh <= agAddr;
      agDataPh <= pci.irdyAg;
      phasePar <= calcPar;
      if (agAddr)
      begin
        agSpecial <= pci.cbe == CMD_SPECIAL;
        memAddr <= pci.ad;
      end
      // par for a phase arrives one clock later
      parErrEv <= (agAddrPh || agDataPh) && parBad;
      addrErrEv <= agAddrPh && parBad;
      pci.perrBr <= agDataPh && !agSpecial && parBad &&
        cmdReg[CMD_PERR_RESP_BIT];
      pci.serrBr <= (agAddrPh || (agDataPh && agSpecial)) &&
        parBad && cmdReg[CMD_PERR_RESP_BIT] && cmdReg[CMD_SERR_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // target decode: system memory window and legacy claim
  // ---------------------------------------------------------------
  wire memCmd = (pci.cbe == CMD_MEM_RD) || (pci.cbe == CMD_MEM_WR);
  wire inWin = pci.ad >= SYSMEM_BASE; // top is 0xffff_ffff
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pci.devselBr <= 1'b0;
      pci.trdyBr <= 1'b0;
      memClaim <= 1'b0;
    end
    else
    begin
      if (agAddr)
        memClaim <= claimReq || (memCmd && inWin);
      else if (!pci.frameAg && !pci.irdyAg)
        memClaim <= 1'b0;
      pci.devselBr <= (agAddr && (claimReq || (memCmd && inWin))) ||
        (pci.devselBr && (pci.frameAg || pci.irdyAg));
      pci.trdyBr <= pci.devselBr && pci.irdyAg;
    end
  end

  // ---------------------------------------------------------------
  // flush handshake
  // ---------------------------------------------------------------
  logic [1:0] holdCnt;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ackOn <= 1'b0;
      holdCnt <= 2'h0;
      pci.bufferFlushAckN <= 1'b1;
    end
    else
    begin
      if (flushReq && !busy && !launch)
      begin
        ackOn <= 1'b1;
        holdCnt <= 2'(FLUSH_ACK_HOLD);
      end
      else if (ackOn && !flushReq)
      begin
        holdCnt <= holdCnt - 2'h1;
        if (holdCnt == 2'h1)
          ackOn <= 1'b0;
      end
      pci.bufferFlushAckN <= !ackOn;
    end
  end
endmodule : pcs_bridge

// *** pcs_agent.sv ***
// agent end: a pci master that reads/writes memory and drives sidebands
`timescale 1ns/1ps
module pcs_agent (
  input wire logic clk, // 125 mhz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic start, // pulse: begin one memory transaction
  input wire logic write, // transaction direction
  input wire logic [31:0] addr, // transaction address
  input wire logic [31:0] wdata, // write data
  input wire logic legacy, // hold legacy claim during own grant
  input wire logic flushGo, // level: request buffer flush
  output logic busy, // transaction in progress
  output logic claimed, // target answered with devsel
  output logic flushDone, // flush acknowledged (synchronised)
  output logic gotPerr, // perr or serr seen from bridge
  pcs_if.agent pci // pci side
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // sideband synchroniser and flush request
  // ---------------------------------------------------------------
  logic ackS1, ackS2, reqOn;
  always_ff @(posedge clk)
  begin
    ackS1 <= pci.bufferFlushAckN;
    ackS2 <= ackS1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqOn <= 1'b0;
      flushDone <= 1'b0;
      gotPerr <= 1'b0;
      pci.bufferFlushRequestN <= 1'b1;
    end
    else
    begin
      // no re-request while the acknowledge is still low
      if (flushGo && !reqOn && ackS2)
        reqOn <= 1'b1;
      else if (!flushGo)
        reqOn <= 1'b0;
      pci.bufferFlushRequestN <= !reqOn;
      flushDone <= !ackS2;
      gotPerr <= gotPerr | pci.perrBr | pci.serrBr;
    end
  end

  // ---------------------------------------------------------------
  // single-data-phase master with parity one clock behind
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AG_IDLE = 2'b00,
    AG_ADDR = 2'b01,
    AG_DATA = 2'b11,
    AG_END = 2'b10
  } pcs_ag_t;
  pcs_ag_t st;
  logic [3:0] tmo;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= AG_IDLE;
      busy <= 1'b0;
      claimed <= 1'b0;
      tmo <= 4'h0;
      pci.adAg <= 32'h0000_0000;
      pci.adAgOe <= 1'b0;
      pci.cbeAg <= 4'h0;
      pci.cbeAgOe <= 1'b0;
      pci.frameAg <= 1'b0;
      pci.irdyAg <= 1'b0;
      pci.legacyMasterClaimN <= 1'b1;
      pci.parAg <= 1'b0;
      pci.parAgOe <= 1'b0;
      pci.perrAg <= 1'b0;
      pci.serrAg <= 1'b0;
    end
    else
    begin
      pci.parAg <= ^{pci.adAg, pci.cbeAg};
      pci.parAgOe <= pci.adAgOe;
      case (st)
        AG_IDLE:
        begin
          // claim stands ahead of the frame so the far synchroniser sees it
          pci.legacyMasterClaimN <= !legacy;
          if (start)
          begin
            st <= AG_ADDR;
            busy <= 1'b1;
            claimed <= 1'b0;
            pci.adAg <= addr;
            pci.cbeAg <= write ? CMD_MEM_WR : CMD_MEM_RD;
            pci.adAgOe <= 1'b1;
            pci.cbeAgOe <= 1'b1;
            pci.frameAg <= 1'b1;
          end
        end
        AG_ADDR:
        begin
          st <= AG_DATA;
          pci.frameAg <= 1'b0;
          pci.irdyAg <= 1'b1;
          pci.cbeAg <= 4'hf;
          pci.adAg <= write ? wdata : 32'h0000_0000; // stable lanes
          pci.adAgOe <= write;
          tmo <= 4'h0;
        end
        AG_DATA:
        begin
          tmo <= tmo + 4'h1;
          if (pci.devselBr)
            claimed <= 1'b1;
          if (pci.trdyBr || tmo == 4'hf)
          begin
            st <= AG_END;
            pci.irdyAg <= 1'b0;
          end
        end
        AG_END:
        begin
          st <= AG_IDLE;
          busy <= 1'b0;
          pci.adAgOe <= 1'b0;
          pci.cbeAgOe <= 1'b0;
          pci.legacyMasterClaimN <= 1'b1;
        end
        default:
          st <= AG_IDLE;
      endcase
    end
  end
endmodule : pcs_agent

// *** pcs_props.sv ***
// checker: pci wire assertions between the bridge and the agent
`timescale 1ns/1ps
module pcs_props (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [31:0] adBr, // bridge ad
  input wire logic adBrOe, // bridge ad enable
  input wire logic [3:0] cbeBr, // bridge c/be
  input wire logic cbeBrOe, // bridge c/be enable
  input wire logic parBr, // bridge par
  input wire logic parBrOe, // bridge par enable
  input wire logic frameBr, // bridge frame
  input wire logic frameAg, // agent frame
  input wire logic irdyBr, // bridge irdy
  input wire logic trdyBr, // bridge trdy
  input wire logic devselBr, // bridge devsel
  input wire logic [31:0] ad, // resolved ad
  input wire logic legacyMasterClaimN, // legacy claim, low active
  input wire logic bufferFlushRequestN, // flush request, low active
  input wire logic bufferFlushAckN // flush ack, low active
);
  import pcs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_special_addr;
    $rose(frameBr) && cbeBr == CMD_SPECIAL;
  endsequence
  sequence s_abort_end;
    ##[1:8] (!irdyBr && !frameBr);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_par_even: assert property (
    adBrOe |=> parBrOe && !(^{$past(adBr), $past(cbeBr), parBr}))
    else $error("bridge parity not even one clock later");
  a_special_data: assert property (
    s_special_addr |=> irdyBr && (adBr[15:0] == MSG_DEEP_SLEEP || adBr[15:0] == MSG_NAP_SLEEP))
    else $error("special data phase wrong");
  a_special_abort: assert property (
    s_special_addr |=> !trdyBr throughout s_abort_end)
    else $error("special cycle not ended by master abort");
  a_addr_driven: assert property (
    $rose(frameBr) |-> adBrOe && cbeBrOe && (cbeBr == CMD_SPECIAL || cbeBr == CMD_CFG_WR))
    else $error("address phase not driven");
  a_type1_low: assert property (
    $rose(frameBr) && cbeBr == CMD_CFG_WR |-> adBr[1:0] == TYPE1_LOW)
    else $error("type 1 low bits wrong");
  a_flush_hold: assert property (
    $rose(bufferFlushRequestN) && !bufferFlushAckN |=> !bufferFlushAckN [*2] ##[1:8] bufferFlushAckN)
    else $error("flush ack hold wrong");
  a_ack_on_req: assert property (
    $fell(bufferFlushAckN) |-> !bufferFlushRequestN)
    else $error("flush ack without request");
  a_legacy_devsel: assert property (
    $rose(frameAg) && !legacyMasterClaimN && !$past(legacyMasterClaimN, 3) |-> ##[1:2] devselBr)
    else $error("legacy claim not answered");
  a_sysmem_hit: assert property (
    $rose(frameAg) && ad >= SYSMEM_BASE |-> ##[1:2] devselBr)
    else $error("system memory window not claimed");
  a_sysmem_miss: assert property (
    $rose(frameAg) && legacyMasterClaimN && $past(legacyMasterClaimN, 3) && ad < SYSMEM_BASE
    |=> !devselBr [*3])
    else $error("address below window claimed");
endmodule : pcs_props

// *** test_pci_special_cycle_parity_sideband.sv ***
// testbench: bridge and agent joined, driven over ahb and agent controls
`timescale 1ns/1ps
module test_pci_special_cycle_parity_sideband;
  import pcs_pkg::*;
  localparam logic [31:0] SPC = 32'h8000_f800; // enabled, bus 0, device 1f
  logic clk, rst, hsel, hwrite, start, write, legacy, flushGo, prevFrame, grab;
  logic hreadyout, hresp, memClaim, busy, claimed, flushDone, gotPerr;
  logic [31:0] haddr, hwdata, hrdata, addr, wdata, rd, lastAddr, lastData;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lastCbe;
  int errCount, compares, frameCnt;
  pcs_if pciIf();
  pcs_bridge pcs_bridge_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memClaim(memClaim),
    .pci(pciIf.bridge));
  pcs_agent pcs_agent_inst (.clk(clk), .rst(rst), .start(start), .write(write), .addr(addr),
    .wdata(wdata), .legacy(legacy), .flushGo(flushGo), .busy(busy), .claimed(claimed),
    .flushDone(flushDone), .gotPerr(gotPerr), .pci(pciIf.agent));
  pcs_props pcs_props_inst (.clk(clk), .rst(rst), .adBr(pciIf.adBr), .adBrOe(pciIf.adBrOe),
    .cbeBr(pciIf.cbeBr), .cbeBrOe(pciIf.cbeBrOe), .parBr(pciIf.parBr),
    .parBrOe(pciIf.parBrOe), .frameBr(pciIf.frameBr), .frameAg(pciIf.frameAg),
    .irdyBr(pciIf.irdyBr), .trdyBr(pciIf.trdyBr), .devselBr(pciIf.devselBr), .ad(pciIf.ad),
    .legacyMasterClaimN(pciIf.legacyMasterClaimN),
    .bufferFlushRequestN(pciIf.bufferFlushRequestN),
    .bufferFlushAckN(pciIf.bufferFlushAckN));
  // ---------------------------------------------------------------
  // clock, watchdog and frame monitor
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #(20000 * 8);
    errCount++;
    finishTest;
  end
  // logs command, address and first data word of each bridge frame
  always @(posedge clk)
  begin
    prevFrame <= pciIf.frameBr;
    grab <= pciIf.frameBr && !prevFrame;
    if (pciIf.frameBr && !prevFrame)
    begin
      frameCnt <= frameCnt + 1;
      lastCbe <= pciIf.cbeBr;
      lastAddr <= pciIf.adBr;
    end
    if (grab)
      lastData <= pciIf.adBr;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task finishTest;
    $display("errors %0d compares %0d", errCount, compares);
    if (errCount == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finishTest
  // one single ahb transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // load the address port, write the data port n times, count frames
  task cfgRun(input logic [31:0] ca, input logic [31:0] d, input int n, input int nExp);
    int f0;
    ahb(1'b1, REG_CFG_ADDR, ca);
    f0 = frameCnt;
    repeat (n) ahb(1'b1, REG_CFG_DATA, d);
    repeat (30) @(posedge clk);
    chk(frameCnt - f0, nExp);
  endtask : cfgRun
  // one agent memory transaction, watching the claim
  task memRun(input logic [31:0] a, input logic leg, input logic exp);
    logic seen;
    seen = 1'b0;
    legacy <= leg;
    addr <= a;
    write <= a[4];
    wdata <= ~a;
    repeat (4) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (memClaim === 1'b1)
        seen = 1'b1;
      if (busy === 1'b0 && i > 2)
        break;
    end
    chk(claimed, exp);
    chk(seen, exp);
    legacy <= 1'b0;
    @(posedge clk);
  endtask : memRun
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task testRegs;
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_CMD, 32'h3);
    ahb(1'b0, REG_CMD, 32'h0);
    chk(rd[1:0], 2'b11);
    ahb(1'b1, REG_PM_CFG, 32'h3);
    ahb(1'b0, REG_PM_CFG, 32'h0);
    chk(rd[1:0], 2'b11);
  endtask : testRegs
  task testSpecial;
    cfgRun(SPC, 32'habcd_0001, 2, 2);
    chk(lastCbe, CMD_SPECIAL);
    chk(lastData, 32'habcd_0001);
    cfgRun(SPC, 32'h1234_0000, 1, 1);
    chk(lastData, 32'h1234_0000);
    chk(lastAddr, SPC);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_MABORT_BIT], 1'b0);
  endtask : testSpecial
  task testRefused;
    ahb(1'b1, REG_PM_CFG, 32'h1);
    cfgRun(SPC, 32'h0000_0001, 1, 0);
    cfgRun(SPC, 32'h0000_0000, 1, 1);
    ahb(1'b1, REG_PM_CFG, 32'h3);
    cfgRun(SPC, {16'h0, MSG_UNUSED}, 1, 0);
    cfgRun(SPC, 32'h0000_ffff, 1, 0);
    cfgRun(32'h0000_f800, 32'h1, 1, 0);
    cfgRun(32'h0005_f804, 32'h1, 1, 0);
  endtask : testRefused
  task testType1;
    cfgRun(32'h8005_f804, 32'h5555_aaaa, 1, 1);
    chk(lastCbe, CMD_CFG_WR);
    chk(lastAddr, 32'h8005_f805);
    chk(lastData, 32'h5555_aaaa);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_MABORT_BIT], 1'b1);
    ahb(1'b1, REG_STATUS, 32'h2);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_MABORT_BIT], 1'b0);
  endtask : testType1
  task testFlush;
    int i;
    flushGo <= 1'b1;
    for (i = 0; i < 40 && flushDone !== 1'b1; i++) @(posedge clk);
    chk(flushDone, 1'b1);
    chk(pciIf.bufferFlushAckN, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_FLUSH_ACK_BIT], 1'b1);
    cfgRun(SPC, 32'h0000_0001, 1, 0);
    flushGo <= 1'b0;
    for (i = 0; i < 40 && pciIf.bufferFlushAckN !== 1'b1; i++) @(posedge clk);
    chk(pciIf.bufferFlushAckN, 1'b1);
    chk(i > 2, 1'b1);
    repeat (8) @(posedge clk);
  endtask : testFlush
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst, hsel, hwrite, start, write, legacy, flushGo, prevFrame, grab} = 9'h100;
    {haddr, hwdata, addr, wdata} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    frameCnt = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    testRegs;
    testSpecial;
    testRefused;
    testType1;
    memRun(32'h8000_1000, 1'b0, 1'b1);
    memRun(32'hffff_fff0, 1'b0, 1'b1);
    memRun(32'h7fff_fff0, 1'b0, 1'b0);
    memRun(32'h0000_1000, 1'b1, 1'b1);
    testFlush;
    chk(gotPerr, 1'b0);
    finishTest;
  end
endmodule : test_pci_special_cycle_parity_sideband
